// ---- serial_port_map.svh ----
// Constants for the dual-mode serial port: codes, counts and addresses.
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH

// Bits in one serial byte, and the counter values around it.
`define SP_BYTE_BITS      4'h8
`define SP_LAST_BIT       4'h7
`define SP_CNT_ZERO       4'h0
`define SP_CNT_ONE        4'h1

// Strap level codes as delivered by the three-level input pad.
`define SP_STRAP_LOW      2'h0
`define SP_STRAP_FLOAT    2'h1
`define SP_STRAP_HIGH     2'h2

// Target addresses selected by the strap.
`define SP_ADDR_LOW       7'h48
`define SP_ADDR_FLOAT     7'h4a
`define SP_ADDR_HIGH      7'h4b

// Byte positions inside an SPI frame and the read flag of the command byte.
`define SP_SPI_CMD_BYTE   2'h0
`define SP_SPI_PTR_BYTE   2'h1
`define SP_SPI_DATA_BYTE  2'h2
`define SP_SPI_READ_BIT   0

// Positions of the external inputs in the synchroniser vector.
`define SP_PIN_CS_N       4
`define SP_PIN_SCL        3
`define SP_PIN_SDA        2
`define SP_PIN_STRAP_HI   1
`define SP_PIN_STRAP_LO   0
`define SP_PIN_COUNT      5

`endif

// ---- serial_port_pkg.sv ----
// Types shared by the dual-mode serial port.
package serial_port_pkg;

  // Raw pin levels arriving from outside the clock domain.
  typedef struct packed {
    logic       cs_n;
    logic       scl;
    logic       sda;
    logic [1:0] strap;
  } pins_in_t;

  // Register access request towards the register file.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } reg_req_t;

  // Open-drain pin drive: output level and enable.
  typedef struct packed {
    logic o;
    logic oe;
  } od_pin_t;

  // Target protocol states.
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_ACK_A, I_WR, I_ACK_W, I_RD, I_RD_ACK
  } i2c_state_t;

endpackage

// ---- serial_port_pins.sv ----
// Dual-mode serial port: two-wire target or four-wire slave, plus interrupt.
//
// Contract
// - Active-low chip select frames every SPI transfer and marks synchronisation.
// - Falling chip select enables the input shift register for following clocks.
// - SPI samples input on rising clock edges, drives output on falling edges.
// - SPI output presents any readable register, one bit per serial clock.
// - SPI output bit changes on falling clock edge for host rising sampling.
// - Strap low, floating, high selects addresses 1001000, 1001010, 1001011.
// - Strapped address is not captured until seen in two valid communications.
// - Address latched on eighth clock of the second valid communication.
// - After latching, strap changes have no effect until power cycles.
// - Two-wire write data on SDA loads into the addressed register.
// - Interrupt asserts whenever a monitored value exceeds its limit.
// - Interrupt active level is configurable low or high.
// - After reset interrupt is active low and driven open drain.
// - SPI input data shifts into the addressed register on rising edges.
`timescale 1ns/10ps
`include "serial_port_map.svh"

module serial_port_pins (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // Serial pins and strap, asynchronous to clk.
  input  wire serial_port_pkg::pins_in_t pins_in,
  // Open-drain data line (SDA in two-wire mode) and SPI data output.
  output serial_port_pkg::od_pin_t       sda_pin,
  output serial_port_pkg::od_pin_t       dout_pin,
  // Interrupt pin and its configuration and cause.
  output serial_port_pkg::od_pin_t       int_pin,
  input  wire logic                      int_active_high,
  input  wire logic                      limit_exceeded,
  // Register file access.
  output serial_port_pkg::reg_req_t      reg_req,
  input  wire logic [7:0]                reg_rdata,
  // Status.
  output logic                           spi_mode,
  output logic                           addr_locked,
  output logic [6:0]                     target_addr
);

  // ***********************************************************************
  // Input synchronisers
  // ***********************************************************************

  logic [`SP_PIN_COUNT-1:0] raw_w, s1_r, s2_r, s3_r, f_r, f_prev_r;

  assign raw_w = pins_in;

  // Three flops per pin; a level counts only once stages two and three agree,
  // which rejects a single-cycle glitch at the cost of one more cycle.
  for (genvar i = 0; i < `SP_PIN_COUNT; i++) begin : g_sync
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        s1_r[i]     <= 1'b1;
        s2_r[i]     <= 1'b1;
        s3_r[i]     <= 1'b1;
        f_r[i]      <= 1'b1;
        f_prev_r[i] <= 1'b1;
      end else begin
        s1_r[i]     <= raw_w[i];
        s2_r[i]     <= s1_r[i];
        s3_r[i]     <= s2_r[i];
        f_prev_r[i] <= f_r[i];
        if (s2_r[i] == s3_r[i]) begin
          f_r[i] <= s3_r[i];
        end
      end
    end
  end

  // ***********************************************************************
  // Edge and condition decode
  // ***********************************************************************

  logic       cs_n_w, cs_fall_w, scl_rise_w, scl_fall_w, sda_w;
  logic       start_w, stop_w;
  logic [1:0] strap_w;
  logic [6:0] strap_addr_w;

  // Chip select low means an SPI frame; high leaves the two-wire target.
  assign cs_n_w     = f_r[`SP_PIN_CS_N];
  assign cs_fall_w  = f_prev_r[`SP_PIN_CS_N] & ~cs_n_w;
  assign scl_rise_w = ~f_prev_r[`SP_PIN_SCL] & f_r[`SP_PIN_SCL];
  assign scl_fall_w = f_prev_r[`SP_PIN_SCL] & ~f_r[`SP_PIN_SCL];
  assign sda_w      = f_r[`SP_PIN_SDA];
  // Start and stop only count while the clock stays high across the change.
  assign start_w = cs_n_w & f_r[`SP_PIN_SCL] & f_prev_r[`SP_PIN_SCL]
                 & f_prev_r[`SP_PIN_SDA] & ~sda_w;
  assign stop_w  = cs_n_w & f_r[`SP_PIN_SCL] & f_prev_r[`SP_PIN_SCL]
                 & ~f_prev_r[`SP_PIN_SDA] & sda_w;
  assign strap_w = f_r[`SP_PIN_STRAP_HI:`SP_PIN_STRAP_LO];

  // Strap level selects the target address.
  assign strap_addr_w = (strap_w == `SP_STRAP_HIGH)  ? `SP_ADDR_HIGH  :
                        (strap_w == `SP_STRAP_FLOAT) ? `SP_ADDR_FLOAT :
                                                       `SP_ADDR_LOW;

  // ***********************************************************************
  // Shared byte engine state
  // ***********************************************************************

  serial_port_pkg::i2c_state_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, tx_r, ptr_r, wdata_r, byte_in_w;
  logic       rw_r, first_r, spi_rd_r, spi_load_r, we_r;
  logic       seen_once_r, latched_r, sda_low_r, dout_low_r;
  logic       mode_spi_r, last_rise_w, addr_hit_w;
  logic [1:0] spi_byte_r;
  logic [6:0] addr_r, cur_addr_w;

  assign byte_in_w   = {sh_r[6:0], sda_w};
  assign last_rise_w = scl_rise_w & (cnt_r == `SP_LAST_BIT);
  // Once latched, the strap is no longer looked at.
  assign cur_addr_w  = latched_r ? addr_r : strap_addr_w;
  assign addr_hit_w  = (sh_r[6:0] == cur_addr_w);

  // ***********************************************************************
  // Strap address capture
  // ***********************************************************************

  // The eighth rising clock of an address byte that matches counts as a
  // valid communication; the second one freezes the address for good.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_once_r <= 1'b0;
      latched_r   <= 1'b0;
      addr_r      <= `SP_ADDR_LOW;
    end else if (cs_n_w && st_r == serial_port_pkg::I_ADDR && last_rise_w &&
                 addr_hit_w && !latched_r) begin
      seen_once_r <= 1'b1;
      if (seen_once_r) begin
        latched_r <= 1'b1;
        addr_r    <= strap_addr_w;
      end
    end
  end

  // ***********************************************************************
  // Protocol engine
  // ***********************************************************************

  // One process serves both modes: the pins are shared, and a chip select
  // edge pulls the engine out of any two-wire transfer in progress.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r       <= serial_port_pkg::I_IDLE;
      cnt_r      <= `SP_CNT_ZERO;
      sh_r       <= 8'h00;
      rw_r       <= 1'b0;
      first_r    <= 1'b0;
      spi_byte_r <= `SP_SPI_CMD_BYTE;
      spi_rd_r   <= 1'b0;
      spi_load_r <= 1'b0;
      tx_r       <= 8'h00;
      ptr_r      <= 8'h00;
      wdata_r    <= 8'h00;
      we_r       <= 1'b0;
      sda_low_r  <= 1'b0;
      dout_low_r <= 1'b0;
      mode_spi_r <= 1'b0;
    end else begin
      we_r       <= 1'b0;
      spi_load_r <= 1'b0;
      mode_spi_r <= ~cs_n_w;
      if (spi_load_r) begin
        tx_r <= reg_rdata;
      end
      if (cs_fall_w) begin
        // Frame start resets the bit counter and the byte position.
        st_r       <= serial_port_pkg::I_IDLE;
        cnt_r      <= `SP_CNT_ZERO;
        spi_byte_r <= `SP_SPI_CMD_BYTE;
        spi_rd_r   <= 1'b0;
        sda_low_r  <= 1'b0;
        dout_low_r <= 1'b0;
      end else if (!cs_n_w) begin
        ptr_r <= ptr_r + {7'h00, we_r};
        if (scl_rise_w) begin
          sh_r  <= byte_in_w;
          cnt_r <= cnt_r + `SP_CNT_ONE;
          if (cnt_r == `SP_LAST_BIT) begin
            cnt_r <= `SP_CNT_ZERO;
            case (spi_byte_r)
              `SP_SPI_CMD_BYTE: begin
                rw_r       <= byte_in_w[`SP_SPI_READ_BIT];
                spi_byte_r <= `SP_SPI_PTR_BYTE;
              end
              `SP_SPI_PTR_BYTE: begin
                ptr_r      <= byte_in_w;
                spi_byte_r <= `SP_SPI_DATA_BYTE;
                spi_rd_r   <= rw_r;
                spi_load_r <= rw_r;
              end
              default: begin
                if (!rw_r) begin
                  wdata_r <= byte_in_w;
                  we_r    <= 1'b1;
                end
                ptr_r      <= ptr_r + {7'h00, rw_r};
                spi_load_r <= rw_r;
              end
            endcase
          end
        end
        if (scl_fall_w && spi_rd_r) begin
          // Open drain: pull low for a zero, release for a one.
          dout_low_r <= ~tx_r[7];
          tx_r       <= {tx_r[6:0], 1'b0};
        end
      end else if (stop_w) begin
        st_r      <= serial_port_pkg::I_IDLE;
        sda_low_r <= 1'b0;
        dout_low_r <= 1'b0;
      end else if (start_w) begin
        st_r      <= serial_port_pkg::I_ADDR;
        cnt_r     <= `SP_CNT_ZERO;
        sda_low_r <= 1'b0;
        dout_low_r <= 1'b0;
      end else begin
        case (st_r)
          serial_port_pkg::I_ADDR, serial_port_pkg::I_WR: begin
            if (scl_rise_w && cnt_r != `SP_BYTE_BITS) begin
              sh_r  <= byte_in_w;
              cnt_r <= cnt_r + `SP_CNT_ONE;
            end
            if (scl_fall_w && cnt_r == `SP_BYTE_BITS) begin
              cnt_r <= `SP_CNT_ZERO;
              if (st_r == serial_port_pkg::I_ADDR) begin
                rw_r      <= sh_r[0];
                sda_low_r <= (sh_r[7:1] == cur_addr_w);
                st_r      <= (sh_r[7:1] == cur_addr_w) ?
                             serial_port_pkg::I_ACK_A :
                             serial_port_pkg::I_IDLE;
                first_r   <= 1'b1;
              end else begin
                // First byte is the pointer, later bytes are data.
                if (first_r) begin
                  ptr_r <= sh_r;
                end else begin
                  wdata_r <= sh_r;
                  we_r    <= 1'b1;
                end
                sda_low_r <= 1'b1;
                st_r      <= serial_port_pkg::I_ACK_W;
              end
            end
          end
          serial_port_pkg::I_ACK_A: begin
            if (scl_fall_w) begin
              st_r      <= rw_r ? serial_port_pkg::I_RD :
                                  serial_port_pkg::I_WR;
              sda_low_r <= rw_r & ~reg_rdata[7];
              tx_r      <= {reg_rdata[6:0], 1'b0};
            end
          end
          serial_port_pkg::I_ACK_W: begin
            if (scl_fall_w) begin
              sda_low_r <= 1'b0;
              st_r      <= serial_port_pkg::I_WR;
              first_r   <= 1'b0;
              if (!first_r) begin
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          serial_port_pkg::I_RD: begin
            if (scl_rise_w) begin
              cnt_r <= cnt_r + `SP_CNT_ONE;
            end
            if (scl_fall_w) begin
              if (cnt_r == `SP_BYTE_BITS) begin
                cnt_r     <= `SP_CNT_ZERO;
                sda_low_r <= 1'b0;
                ptr_r     <= ptr_r + 8'h01;
                st_r      <= serial_port_pkg::I_RD_ACK;
              end else begin
                sda_low_r <= ~tx_r[7];
                tx_r      <= {tx_r[6:0], 1'b0};
              end
            end
          end
          serial_port_pkg::I_RD_ACK: begin
            // A high level on the ninth clock is the host's not-acknowledge.
            if (scl_rise_w) begin
              rw_r <= ~sda_w;
            end
            if (scl_fall_w) begin
              st_r      <= rw_r ? serial_port_pkg::I_RD :
                                  serial_port_pkg::I_IDLE;
              sda_low_r <= rw_r & ~reg_rdata[7];
              tx_r      <= {reg_rdata[6:0], 1'b0};
            end
          end
          default: begin
            st_r <= serial_port_pkg::I_IDLE;
          end
        endcase
      end
    end
  end

  // ***********************************************************************
  // Interrupt
  // ***********************************************************************

  logic pol_high_r, int_low_r;

  // Polarity resets to active low; the pin only ever pulls low, so the
  // active-high setting releases the line while a limit is exceeded.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pol_high_r <= 1'b0;
      int_low_r  <= 1'b0;
    end else begin
      pol_high_r <= int_active_high;
      int_low_r  <= limit_exceeded ^ pol_high_r;
    end
  end

  // ***********************************************************************
  // Outputs
  // ***********************************************************************

  assign sda_pin       = '{o: 1'b0, oe: sda_low_r};
  assign dout_pin      = '{o: 1'b0, oe: dout_low_r};
  assign int_pin       = '{o: 1'b0, oe: int_low_r};
  assign reg_req.addr  = ptr_r;
  assign reg_req.wdata = wdata_r;
  assign reg_req.we    = we_r;
  assign spi_mode      = mode_spi_r;
  assign addr_locked   = latched_r;
  assign target_addr   = addr_r;

endmodule // serial_port_pins

// ---- serial_port_pins_sva.sv ----
// Concurrent checks on the ports of the dual-mode serial port.
`timescale 1ns/10ps

module serial_port_pins_sva (
  // Clock and reset.
  input wire logic                      clk,
  input wire logic                      reset_n,
  // Pins and configuration.
  input wire serial_port_pkg::pins_in_t pins_in,
  input wire serial_port_pkg::od_pin_t  sda_pin,
  input wire serial_port_pkg::od_pin_t  dout_pin,
  input wire serial_port_pkg::od_pin_t  int_pin,
  input wire logic                      int_active_high,
  input wire logic                      limit_exceeded,
  // Register side and status.
  input wire serial_port_pkg::reg_req_t reg_req,
  input wire logic [7:0]                reg_rdata,
  input wire logic                      spi_mode,
  input wire logic                      addr_locked,
  input wire logic [6:0]                target_addr
);
  // ************************************************************
  // Port relations, all in the clk domain.
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  int_low_a: assert property ((limit_exceeded && !int_active_high) [*3]
    |-> int_pin.oe) else $error("low interrupt not pulled");
  int_high_a: assert property ((!limit_exceeded && int_active_high) [*3]
    |-> int_pin.oe) else $error("inactive high line not low");
  int_idle_a: assert property ((!limit_exceeded && !int_active_high) [*3]
    |-> !int_pin.oe) else $error("idle interrupt pulled");
  int_rel_a: assert property ((limit_exceeded && int_active_high) [*3]
    |-> !int_pin.oe) else $error("active high not released");
  sda_od_a: assert property (sda_pin.o == 1'b0)
    else $error("data line driven high");
  dout_od_a: assert property (dout_pin.o == 1'b0)
    else $error("serial output driven high");
  two_wire_a: assert property (pins_in.cs_n [*8] |-> !spi_mode)
    else $error("four-wire mode with select high");
  four_wire_a: assert property (!pins_in.cs_n [*8] |-> spi_mode)
    else $error("select low but not framed");
  lock_hold_a: assert property (addr_locked |=>
    addr_locked && $stable(target_addr))
    else $error("latched address moved");
  addr_map_a: assert property ($rose(addr_locked) |->
    target_addr inside {7'h48, 7'h4a, 7'h4b})
    else $error("latched address not a strap value");
  we_pulse_a: assert property (reg_req.we |=> !reg_req.we)
    else $error("write strobe longer than one cycle");

endmodule // serial_port_pins_sva

bind serial_port_pins serial_port_pins_sva u_sva (
  .clk(clk), .reset_n(reset_n), .pins_in(pins_in), .sda_pin(sda_pin),
  .dout_pin(dout_pin), .int_pin(int_pin), .int_active_high(int_active_high),
  .limit_exceeded(limit_exceeded), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .spi_mode(spi_mode), .addr_locked(addr_locked), .target_addr(target_addr));

// ---- host_model.sv ----
// Host bus controller model driving the serial pins in either mode.
`timescale 1ns/10ps

module host_model (
  // Clock used to pace the pins.
  input wire logic                      clk,
  // Device pin drives.
  input wire serial_port_pkg::od_pin_t  sda_pin,
  input wire serial_port_pkg::od_pin_t  dout_pin,
  // Wire levels seen by the device.
  output serial_port_pkg::pins_in_t     pins_in
);
  logic       cs_n_r = 1'b1;
  logic       scl_r  = 1'b1;
  logic       sda_r  = 1'b1;
  logic [1:0] strap_r = 2'h1;

  // Pulled-up data wire: low when either side pulls it down.
  assign pins_in = '{cs_n: cs_n_r, scl: scl_r,
                     sda: sda_r & ~sda_pin.oe, strap: strap_r};

  // ************************************************************
  // Pin sequences.
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Output is sampled late in the high phase because the device
  // sees the clock through a synchroniser.
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      scl_r <= 1'b0;
      sda_r <= tx[i];
      tick(4);
      scl_r <= 1'b1;
      tick(4);
      rx[i] = ~dout_pin.oe;
    end
  endtask

  // Select frames the whole transfer; clock idles high.
  task automatic spi_frame(input logic [7:0] c, p, d, output logic [7:0] r);
    logic [7:0] x;
    cs_n_r <= 1'b0;
    tick(8);
    spi_byte(c, x);
    spi_byte(p, x);
    spi_byte(d, r);
    tick(8);
    cs_n_r <= 1'b1;
    tick(8);
  endtask

  // Data changes only while the clock is low.
  task automatic i2c_bit(input logic b, output logic seen);
    sda_r <= b;
    tick(4);
    scl_r <= 1'b1;
    tick(4);
    seen = pins_in.sda;
    scl_r <= 1'b0;
    tick(4);
  endtask

  task automatic i2c_byte(input logic [7:0] tx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) i2c_bit(tx[i], s);
    i2c_bit(1'b1, s);
    ack = ~s;
  endtask

  // Start: the data line is raised first, since a four-wire frame may have
  // left it low, and a start needs a falling edge under a high clock.
  task automatic i2c_start;
    cs_n_r <= 1'b1;
    sda_r  <= 1'b1;
    tick(8);
    sda_r  <= 1'b0;
    tick(4);
    scl_r <= 1'b0;
    tick(4);
  endtask

  // Stop: data rises while the clock is high.
  task automatic i2c_stop;
    sda_r <= 1'b0;
    tick(4);
    scl_r <= 1'b1;
    tick(4);
    sda_r <= 1'b1;
    tick(8);
  endtask

  // Start, address with write, pointer, one data byte, stop.
  task automatic i2c_write(input logic [6:0] a, input logic [7:0] p, d,
                           output logic ack);
    logic k;
    i2c_start;
    i2c_byte({a, 1'b0}, ack);
    if (ack) begin
      i2c_byte(p, k);
      i2c_byte(d, k);
    end
    i2c_stop;
  endtask

  // Start, address with read, one byte closed by not-acknowledge, stop.
  task automatic i2c_read(input logic [6:0] a, output logic [7:0] d);
    logic k;
    i2c_start;
    i2c_byte({a, 1'b1}, k);
    for (int i = 7; i >= 0; i--) i2c_bit(1'b1, d[i]);
    i2c_bit(1'b1, k);
    i2c_stop;
  endtask

endmodule // host_model

// ---- serial_port_pins_tb.sv ----
// Self-checking bench for the dual-mode serial port pins.
`timescale 1ns/10ps

module serial_port_pins_tb;
  logic                      clk = 1'b0;
  logic                      reset_n = 1'b0;
  logic                      int_active_high = 1'b0;
  logic                      limit_exceeded = 1'b0;
  logic [7:0]                reg_rdata;
  serial_port_pkg::pins_in_t pins_in;
  serial_port_pkg::od_pin_t  sda_pin, dout_pin, int_pin;
  serial_port_pkg::reg_req_t reg_req;
  logic                      spi_mode, addr_locked;
  logic [6:0]                target_addr;
  logic [7:0]                wr_addr = 8'h00, wr_data = 8'h00;
  logic [7:0]                rd;
  logic                      ack;
  int                        n_fail = 0, checks = 0;

  initial forever #2 clk = ~clk;

  // Register file stand-in: read data follows the pointer at once.
  assign reg_rdata = reg_req.addr ^ 8'ha5;

  // Keep the last write seen on the register side.
  always @(posedge clk) if (reg_req.we === 1'b1) begin
    wr_addr <= reg_req.addr;
    wr_data <= reg_req.wdata;
  end

  serial_port_pins DUT (.clk(clk), .reset_n(reset_n), .pins_in(pins_in),
    .sda_pin(sda_pin), .dout_pin(dout_pin), .int_pin(int_pin),
    .int_active_high(int_active_high), .limit_exceeded(limit_exceeded),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .spi_mode(spi_mode),
    .addr_locked(addr_locked), .target_addr(target_addr));

  host_model host (.clk(clk), .sda_pin(sda_pin), .dout_pin(dout_pin),
                   .pins_in(pins_in));

  // ************************************************************
  // Checking and scenarios.
  // ************************************************************
  task automatic chk(input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic t_reset;
    chk(int_pin.oe, 1'b0);
    chk(target_addr, 7'h48);
    chk(addr_locked, 1'b0);
    chk(spi_mode, 1'b0);
  endtask

  // Every polarity and limit combination; pulled means asserted low.
  task automatic t_irq;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      int_active_high <= k[1];
      limit_exceeded <= k[0];
      repeat (4) @(posedge clk);
      chk(int_pin.oe, k[1] ^ k[0]);
    end
    limit_exceeded <= 1'b0;
    int_active_high <= 1'b0;
  endtask

  // The strobe must carry the pointer the frame addressed.
  task automatic t_spi_write;
    host.spi_frame(8'h00, 8'h3c, 8'hd2, rd);
    chk(wr_data, 8'hd2);
    chk(wr_addr, 8'h3c);
  endtask

  task automatic t_spi_read;
    host.spi_frame(8'h01, 8'h71, 8'h00, rd);
    chk(rd, 8'h71 ^ 8'ha5);
  endtask

  // Two addressed writes latch the strap; a later strap move is ignored.
  task automatic t_i2c_lock;
    host.i2c_write(7'h4a, 8'h12, 8'h5c, ack);
    chk(ack, 1'b1);
    chk(wr_addr, 8'h12);
    chk(wr_data, 8'h5c);
    chk(addr_locked, 1'b0);
    host.i2c_write(7'h4a, 8'h13, 8'h6e, ack);
    chk(addr_locked, 1'b1);
    chk(target_addr, 7'h4a);
    host.strap_r <= 2'h2;
    host.i2c_write(7'h4b, 8'h14, 8'h77, ack);
    chk(ack, 1'b0);
    chk(target_addr, 7'h4a);
    chk(wr_data, 8'h6e);
  endtask

  // A two-wire read at the latched address returns the register after
  // the last one written, as the pointer stepped past it.
  task automatic t_i2c_read;
    host.i2c_read(7'h4a, rd);
    chk(rd, (8'h13 + 8'h01) ^ 8'ha5);
  endtask

  // Watchdog sized well past the full sequence.
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    final_report;
  end

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset;
    t_irq;
    t_spi_write;
    t_spi_read;
    t_i2c_lock;
    t_i2c_read;
    final_report;
  end

endmodule // serial_port_pins_tb
